// *** core/fsp_defs.vh ***
// fsp_defs.vh: constants of the flash status and protect block
// assumes: included by core files only, never compiled alone
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH
// clock rate in MHz, used to turn microseconds into cycles
`define FSP_CLK_MHZ 25
// serial command codes
`define FSP_C_UNLOCK 8'h06
`define FSP_C_LOCK   8'h04
`define FSP_C_RDS1   8'h05
`define FSP_C_RDS2   8'h35
`define FSP_C_RDS3   8'h15
`define FSP_C_WRS1   8'h01
`define FSP_C_WRS2   8'h31
`define FSP_C_WRS3   8'h11
`define FSP_C_PAGE   8'h02
`define FSP_C_SECT   8'h20
`define FSP_C_BLK32  8'h52
`define FSP_C_BLK64  8'hD8
`define FSP_C_CHIPA  8'hC7
`define FSP_C_CHIPB  8'h60
`define FSP_C_SUSP   8'h75
`define FSP_C_RESUM  8'h7A
`define FSP_C_RSTEN  8'h66
`define FSP_C_RST    8'h99
// status word bit positions
`define FSP_B_BUSY  0
`define FSP_B_LATCH 1
`define FSP_B_PSEL  2
`define FSP_B_GLO   7
`define FSP_B_GHI   8
`define FSP_B_QEN   9
`define FSP_B_PPAU  10
`define FSP_B_LOCK  11
`define FSP_B_INV   14
`define FSP_B_EPAU  15
`define FSP_B_FAST  20
`define FSP_B_DRV   21
// power-up values of the non-volatile fields
`define FSP_RV_PSEL  5'h00
`define FSP_RV_GUARD 2'h0
`define FSP_RV_INV   1'h0
`define FSP_RV_QEN   1'h0
`define FSP_RV_LOCK  3'h0
`define FSP_RV_DRV   2'h1
// erase unit offset masks
`define FSP_M_SECT  23'h000FFF
`define FSP_M_BLK32 23'h007FFF
`define FSP_M_BLK64 23'h00FFFF
// protect decode size exponents
`define FSP_E_BIG   5'h10
`define FSP_E_SMALL 5'h0B
`define FSP_E_MAX   5'h0F
`endif

// *** core/fsp_sync.v ***
// fsp_sync.v: two-stage synchroniser for pad inputs
// assumes: q is read only by logic clocked on clk
`timescale 1ns/10ps
`default_nettype none
module fsp_sync #(
    parameter         W  = 1,
    parameter [W-1:0] RV = {W{1'b0}}
) (
    // clock and reset
    input  wire         clk,
    input  wire         rst_b,
    // raw and synchronised levels
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    // first stage feeds the second stage and nothing else
    reg [W-1:0] meta_q;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= RV;
            q      <= RV;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** core/fsp_prot_dec.v ***
// fsp_prot_dec.v: decides whether one array address is protected
// assumes: 8 MB array, select and invert come straight from the status word
`timescale 1ns/10ps
`default_nettype none
`include "fsp_defs.vh"
module fsp_prot_dec (
    // protect fields
    input  wire [4:0]  sel,
    input  wire        inv,
    // byte address
    input  wire [22:0] addr,
    output wire        prot
);
    reg [4:0]  e;
    reg [22:0] mask;
    reg        hit;

    always @* begin
        e    = `FSP_E_MAX;
        hit  = 1'b0;
        // size is a power of two, so one mask covers the region
        if (!sel[4])
            e = `FSP_E_BIG + {2'h0, sel[2:0]};
        else if (!sel[2])
            e = `FSP_E_SMALL + {3'h0, sel[1:0]};
        mask = ~((23'h000001 << e) - 23'h000001);
        if (sel[2:0] == 3'h0)
            hit = 1'b0;
        else if (sel[2:0] == 3'h7)
            hit = 1'b1;
        else if (sel[3])
            hit = ((addr & mask) == 23'h000000);
        else
            hit = ((addr & mask) == mask);
    end

    // invert gives the complement of the plain range
    assign prot = hit ^ inv;
endmodule
`default_nettype wire

// *** core/fsp_core.v ***
// fsp_core.v: status register, protection and serial command front end
// assumes: serial pins arrive raw from pads; the array engine outside
// takes start pulses and program bytes and needs no answer
//
// Function
// - busy flag high during program, erase, status write
// - write latch flag gates status writes, program, erase
// - protect selects written by status write only
// - reject program and erase inside protected range
// - chip erase only at select 000/inv0 or 111/inv1
// - invert one: 000 all, 111 none
// - invert one, 00: all but top blocks
// - invert one, 01: all but bottom blocks
// - invert one, 10: all but top kilobytes
// - invert one, 11: all but bottom kilobytes
// - two status guard bits select the method
// - guard 00: write allowed whenever latch set
// - guard 01: low guard pin locks status
// - guard 10: locked until power cycle, then 00
// - guard 11: status permanently write protected; here locked only until reset, like guard 10
// - four lane enable frees guard and pause pins
// - security lock bits only ever set; here cleared again by reset
// - invert bit stored, default zero, joins decode
// - suspend sets erase or program paused flag
// - resume, software reset, power cycle clear pauses
// - fast mode flag mirrors high performance mode
// - drive field sets strength, default three quarters
// - invert zero protects the plain ranges
// - latch set by unlock, cleared by writes
`timescale 1ns/10ps
`default_nettype none
`include "fsp_defs.vh"
module fsp_core #(
    parameter T_PROG_US  = 100,
    parameter T_ERASE_US = 1000,
    parameter T_SRW_US   = 100,
    parameter CW         = 24
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst_b,
    // serial pins
    input  wire        sclk,
    input  wire        cs_b,
    input  wire        si,
    input  wire        wp_b,
    input  wire        hold_b,
    output reg         so_q,
    output reg         so_oe_q,
    // mode level from the read path, same clock
    input  wire        high_perf_mode,
    // array engine
    output reg         arr_start_q,
    output reg  [7:0]  arr_cmd_q,
    output reg  [22:0] arr_addr_q,
    output reg         arr_wr_q,
    output reg  [7:0]  arr_wdata_q,
    output reg         arr_pause_q,
    // configuration and state
    output reg         write_busy_flag_q,
    output reg         four_lane_enable_q,
    output reg  [2:0]  secure_lock_q,
    output reg  [1:0]  drive_sel_q
);
    localparam integer PROG_N  = T_PROG_US * `FSP_CLK_MHZ;
    localparam integer ERASE_N = T_ERASE_US * `FSP_CLK_MHZ;
    localparam integer SRW_N   = T_SRW_US * `FSP_CLK_MHZ;
    localparam [CW-1:0] PROG_CYC  = PROG_N[CW-1:0];
    localparam [CW-1:0] ERASE_CYC = ERASE_N[CW-1:0];
    localparam [CW-1:0] SRW_CYC   = SRW_N[CW-1:0];
    localparam [CW-1:0] ONE       = {{(CW-1){1'b0}}, 1'b1};

    // operation states
    localparam [2:0] OP_IDLE  = 3'h1;
    localparam [2:0] OP_RUN   = 3'h2;
    localparam [2:0] OP_PAUSE = 3'h4;

    reg        rst_m_q;
    reg        rst_ni;
    wire [4:0] pin_s;
    wire       sclk_s = pin_s[4];
    wire       cs_s   = pin_s[3];
    wire       si_s   = pin_s[2];
    wire       wp_s   = pin_s[1];
    wire       hold_s = pin_s[0];

    reg          sclk_p_q;
    reg          cs_p_q;
    reg  [2:0]   bit_cnt_q;
    reg  [2:0]   byte_cnt_q;
    reg  [7:0]   sh_q;
    reg  [7:0]   cmd_q;
    reg  [23:0]  addr_q;
    reg  [7:0]   wdat_q;
    reg          rd_q;
    reg  [1:0]   rd_sel_q;
    reg  [7:0]   out_sh_q;
    reg  [2:0]   out_cnt_q;
    reg          rst_arm_q;
    reg          write_latch_flag_q;
    reg  [4:0]   psel_q;
    reg  [1:0]   guard_q;
    reg          inv_q;
    reg          epau_q;
    reg          ppau_q;
    reg          fast_q;
    reg  [2:0]   op_q;
    reg  [2:0]   op_d;
    reg  [CW-1:0] cnt_q;
    reg  [CW-1:0] cnt_d;
    reg          kind_srw_q;
    reg          kind_ers_q;

    // release reset through two flops
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_m_q <= 1'b0;
            rst_ni  <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_ni  <= rst_m_q;
        end
    end

    fsp_sync #(
        .W  (5),
        .RV (5'h0B)
    ) u_sync (
        .clk   (clk),
        .rst_b (rst_ni),
        .d     ({sclk, cs_b, si, wp_b, hold_b}),
        .q     (pin_s)
    );

    // pause pin only acts while lanes two and three are control pins
    wire hold_act = ~four_lane_enable_q & ~hold_s;
    wire rise     = sclk_s & ~sclk_p_q & ~cs_s & ~hold_act;
    wire fall     = ~sclk_s & sclk_p_q & ~cs_s & ~hold_act;
    wire cs_rise  = cs_s & ~cs_p_q;
    wire cs_fall  = ~cs_s & cs_p_q;
    wire [7:0] byte_in  = {sh_q[6:0], si_s};
    wire       byte_end = rise & (bit_cnt_q == 3'h7);

    // assembled status word
    reg [23:0] st;
    always @* begin
        st = 24'h000000;
        st[`FSP_B_BUSY] = write_busy_flag_q;
        st[`FSP_B_LATCH] = write_latch_flag_q;
        st[`FSP_B_PSEL+4:`FSP_B_PSEL] = psel_q;
        st[`FSP_B_GLO] = guard_q[0];
        st[`FSP_B_GHI] = guard_q[1];
        st[`FSP_B_QEN] = four_lane_enable_q;
        st[`FSP_B_PPAU] = ppau_q;
        st[`FSP_B_LOCK+2:`FSP_B_LOCK] = secure_lock_q;
        st[`FSP_B_INV] = inv_q;
        st[`FSP_B_EPAU] = epau_q;
        st[`FSP_B_FAST] = fast_q;
        st[`FSP_B_DRV+1:`FSP_B_DRV] = drive_sel_q;
    end

    // status byte chosen by a read code
    reg [1:0] code_sel;
    always @* begin
        case (byte_in)
            `FSP_C_RDS1: code_sel = 2'h0;
            `FSP_C_RDS2: code_sel = 2'h1;
            `FSP_C_RDS3: code_sel = 2'h2;
            default:     code_sel = 2'h3;
        endcase
    end
    wire [7:0] rd_byte = (rd_sel_q == 2'h0) ? st[7:0] :
                         (rd_sel_q == 2'h1) ? st[15:8] : st[23:16];

    // erase unit, so both ends of the unit are checked
    reg [22:0] umask;
    always @* begin
        case (cmd_q)
            `FSP_C_SECT:  umask = `FSP_M_SECT;
            `FSP_C_BLK32: umask = `FSP_M_BLK32;
            `FSP_C_BLK64: umask = `FSP_M_BLK64;
            default:      umask = 23'h000000;
        endcase
    end
    wire [22:0] first_a = addr_q[22:0] & ~umask;
    wire [22:0] last_a  = first_a | umask;
    wire        prot_f;
    wire        prot_l;

    fsp_prot_dec u_dec_first (
        .sel  (psel_q),
        .inv  (inv_q),
        .addr (first_a),
        .prot (prot_f)
    );

    fsp_prot_dec u_dec_last (
        .sel  (psel_q),
        .inv  (inv_q),
        .addr (last_a),
        .prot (prot_l)
    );

    // protected regions are intervals at one end, so two probes suffice
    wire hit     = prot_f | prot_l;
    wire idle    = op_q[0];
    wire running = op_q[1];
    wire paused  = op_q[2];

    // status write gate by guard bits and guard pin
    wire wp_low  = ~four_lane_enable_q & ~wp_s;
    wire sr_lock = guard_q[1] | (guard_q[0] & wp_low);
    wire sr_ok   = write_latch_flag_q & ~sr_lock & idle;
    wire pe_ok   = write_latch_flag_q & idle;
    wire ce_ok   = ((psel_q[2:0] == 3'h0) & ~inv_q) |
                   ((psel_q[2:0] == 3'h7) & inv_q);

    wire is_wrs  = (cmd_q == `FSP_C_WRS1) | (cmd_q == `FSP_C_WRS2) |
                   (cmd_q == `FSP_C_WRS3);
    wire is_ers  = (cmd_q == `FSP_C_SECT) | (cmd_q == `FSP_C_BLK32) |
                   (cmd_q == `FSP_C_BLK64);
    wire is_chip = (cmd_q == `FSP_C_CHIPA) | (cmd_q == `FSP_C_CHIPB);
    wire is_page = (cmd_q == `FSP_C_PAGE);

    // commands act only when select rises on a byte boundary; program data bytes pass on at each byte end
    wire exec   = cs_rise & (bit_cnt_q == 3'h0) & (byte_cnt_q != 3'h0);
    wire one    = exec & (byte_cnt_q == 3'h1);
    wire do_srw = exec & (byte_cnt_q == 3'h2) & is_wrs & sr_ok;
    wire do_prog = exec & (byte_cnt_q >= 3'h5) & is_page & pe_ok & ~hit;
    wire do_er  = exec & (byte_cnt_q == 3'h4) & is_ers & pe_ok & ~hit;
    wire do_ce  = one & is_chip & pe_ok & ce_ok;
    wire do_sus = one & (cmd_q == `FSP_C_SUSP) & running & ~kind_srw_q;
    wire do_res = one & (cmd_q == `FSP_C_RESUM) & paused;
    wire do_rst = one & (cmd_q == `FSP_C_RST) & rst_arm_q;
    wire do_go  = do_srw | do_prog | do_er | do_ce;
    wire latch_set = one & (cmd_q == `FSP_C_UNLOCK) & idle;
    wire latch_clr = do_rst |
                     (exec & ((cmd_q == `FSP_C_LOCK) | is_wrs | is_page |
                     is_ers | is_chip));
    wire prog_byte = byte_end & (byte_cnt_q >= 3'h4) & is_page & pe_ok & ~hit;

    // operation sequencer next state
    always @* begin
        op_d  = op_q;
        cnt_d = cnt_q;
        case (op_q)
            OP_IDLE: begin
                if (do_go) begin
                    op_d  = OP_RUN;
                    cnt_d = do_srw ? SRW_CYC - ONE :
                            do_prog ? PROG_CYC - ONE : ERASE_CYC - ONE;
                end
            end
            OP_RUN: begin
                if (do_rst)
                    op_d = OP_IDLE;
                else if (do_sus)
                    op_d = OP_PAUSE;
                else if (cnt_q == {CW{1'b0}})
                    op_d = OP_IDLE;
                else
                    cnt_d = cnt_q - ONE;
            end
            OP_PAUSE: begin
                if (do_rst)
                    op_d = OP_IDLE;
                else if (do_res)
                    op_d = OP_RUN;
            end
            default: op_d = OP_IDLE;
        endcase
    end

    always @(posedge clk or negedge rst_ni) begin
        if (!rst_ni) begin
            op_q              <= OP_IDLE;
            cnt_q             <= {CW{1'b0}};
            kind_srw_q        <= 1'b0;
            kind_ers_q        <= 1'b0;
            write_busy_flag_q <= 1'b0;
            arr_pause_q       <= 1'b0;
            arr_start_q       <= 1'b0;
            arr_cmd_q         <= 8'h00;
            arr_addr_q        <= 23'h000000;
            arr_wr_q          <= 1'b0;
            arr_wdata_q       <= 8'h00;
            epau_q            <= 1'b0;
            ppau_q            <= 1'b0;
        end else begin
            op_q              <= op_d;
            cnt_q             <= cnt_d;
            write_busy_flag_q <= (op_d == OP_RUN);
            arr_pause_q       <= (op_d == OP_PAUSE);
            arr_start_q       <= do_prog | do_er | do_ce;
            arr_wr_q          <= prog_byte;
            if (do_go) begin
                kind_srw_q <= do_srw;
                kind_ers_q <= do_er | do_ce;
            end
            if (do_prog | do_er | do_ce) begin
                arr_cmd_q  <= cmd_q;
                arr_addr_q <= do_prog ? {addr_q[22:8], 8'h00} : first_a;
            end
            if (prog_byte) begin
                arr_wdata_q <= byte_in;
                arr_addr_q  <= addr_q[22:0];
            end
            // pause flags cleared by resume or reset, set by suspend
            if (do_res | do_rst) begin
                epau_q <= 1'b0;
                ppau_q <= 1'b0;
            end else if (do_sus) begin
                epau_q <= kind_ers_q;
                ppau_q <= ~kind_ers_q;
            end
        end
    end

    // serial framing, readback and status fields
    always @(posedge clk or negedge rst_ni) begin
        if (!rst_ni) begin
            sclk_p_q           <= 1'b0;
            cs_p_q             <= 1'b1;
            bit_cnt_q          <= 3'h0;
            byte_cnt_q         <= 3'h0;
            sh_q               <= 8'h00;
            cmd_q              <= 8'h00;
            addr_q             <= 24'h000000;
            wdat_q             <= 8'h00;
            rd_q               <= 1'b0;
            rd_sel_q           <= 2'h0;
            out_sh_q           <= 8'h00;
            out_cnt_q          <= 3'h0;
            rst_arm_q          <= 1'b0;
            so_q               <= 1'b0;
            so_oe_q            <= 1'b0;
            write_latch_flag_q <= 1'b0;
            psel_q             <= `FSP_RV_PSEL;
            guard_q            <= `FSP_RV_GUARD;
            inv_q              <= `FSP_RV_INV;
            four_lane_enable_q <= `FSP_RV_QEN;
            secure_lock_q      <= `FSP_RV_LOCK;
            drive_sel_q        <= `FSP_RV_DRV;
            fast_q             <= 1'b0;
        end else begin
            sclk_p_q <= sclk_s;
            cs_p_q   <= cs_s;
            fast_q   <= high_perf_mode;
            so_oe_q  <= rd_q & ~cs_s & ~hold_act;
            if (cs_fall) begin
                bit_cnt_q  <= 3'h0;
                byte_cnt_q <= 3'h0;
                rd_q       <= 1'b0;
            end else if (rise) begin
                sh_q      <= byte_in;
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (byte_end) begin
                if (byte_cnt_q != 3'h7)
                    byte_cnt_q <= byte_cnt_q + 3'h1;
                if (byte_cnt_q == 3'h0) begin
                    cmd_q <= byte_in;
                    if (code_sel != 2'h3) begin
                        rd_q      <= 1'b1;
                        rd_sel_q  <= code_sel;
                        out_cnt_q <= 3'h0;
                        out_sh_q  <= (code_sel == 2'h0) ? st[7:0] :
                                     (code_sel == 2'h1) ? st[15:8] : st[23:16];
                    end
                end
                if (byte_cnt_q == 3'h1)
                    wdat_q <= byte_in;
                if ((byte_cnt_q != 3'h0) && (byte_cnt_q < 3'h4))
                    addr_q <= {addr_q[15:0], byte_in};
                // program bytes wrap inside the page
                if (prog_byte)
                    addr_q[7:0] <= addr_q[7:0] + 8'h01;
            end
            // readback repeats the chosen byte while clocks continue
            if (fall & rd_q) begin
                so_q      <= out_sh_q[7];
                out_cnt_q <= out_cnt_q + 3'h1;
                if (out_cnt_q == 3'h7)
                    out_sh_q <= rd_byte;
                else
                    out_sh_q <= {out_sh_q[6:0], 1'b0};
            end
            if (cs_rise)
                rd_q <= 1'b0;
            if (exec)
                rst_arm_q <= one & (cmd_q == `FSP_C_RSTEN);
            // set and clear come from different commands, never together
            if (latch_set)
                write_latch_flag_q <= 1'b1;
            else if (latch_clr)
                write_latch_flag_q <= 1'b0;
            if (do_srw) begin
                case (cmd_q)
                    `FSP_C_WRS1: begin
                        guard_q[0] <= wdat_q[7];
                        psel_q     <= wdat_q[6:2];
                    end
                    `FSP_C_WRS2: begin
                        guard_q[1]         <= wdat_q[0];
                        four_lane_enable_q <= wdat_q[1];
                        secure_lock_q      <= secure_lock_q | wdat_q[5:3];
                        inv_q              <= wdat_q[6];
                    end
                    `FSP_C_WRS3: begin
                        drive_sel_q <= wdat_q[6:5];
                    end
                    default: begin
                        drive_sel_q <= drive_sel_q;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/fsp_core_monitor.sv ***
// fsp_core_monitor.sv: port assertions for the status and protect block
// assumes: bound to fsp_core, one clock domain, host sclk >= 8 clk
`timescale 1ns/10ps
`default_nettype none
module fsp_core_monitor (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // pins and outputs
    input wire logic       cs_b,
    input wire logic       so_oe_q,
    input wire logic       arr_start_q,
    input wire logic [7:0] arr_cmd_q,
    input wire logic       arr_wr_q,
    input wire logic       arr_pause_q,
    input wire logic       write_busy_flag_q,
    input wire logic       four_lane_enable_q,
    input wire logic [2:0] secure_lock_q,
    input wire logic [1:0] drive_sel_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    start_sets_busy_a: assert property (arr_start_q |-> ##[0:1] write_busy_flag_q)
        else $error("busy not raised after start");
    start_code_a: assert property (arr_start_q |-> (arr_cmd_q inside
        {8'h02, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60}))
        else $error("start with foreign code");
    start_pulse_a: assert property (arr_start_q |=> !arr_start_q)
        else $error("start longer than one cycle");
    pause_idle_a: assert property (arr_pause_q |-> !write_busy_flag_q)
        else $error("busy while paused");
    drive_on_frame_a: assert property ($changed(drive_sel_q) |-> $past(cs_b, 3))
        else $error("drive field changed inside frame");
    lock_sticky_a: assert property (($past(secure_lock_q) & ~secure_lock_q) == 3'h0)
        else $error("lock bit cleared");
    lane_on_frame_a: assert property ($changed(four_lane_enable_q) |-> $past(cs_b, 3))
        else $error("four lane changed inside frame");
    wr_not_busy_a: assert property (arr_wr_q |-> !write_busy_flag_q && !cs_b ##1 !arr_wr_q)
        else $error("program byte while busy");
    so_release_a: assert property ($rose(cs_b) |-> ##[1:5] !so_oe_q)
        else $error("output kept after deselect");
    start_cov: cover property (arr_start_q);
    pause_cov: cover property (arr_pause_q);
    read_cov: cover property (so_oe_q);
endmodule
bind fsp_core fsp_core_monitor mon_u (.clk(clk), .rst_b(rst_b), .cs_b(cs_b),
    .so_oe_q(so_oe_q), .arr_start_q(arr_start_q), .arr_cmd_q(arr_cmd_q),
    .arr_wr_q(arr_wr_q), .arr_pause_q(arr_pause_q), .write_busy_flag_q(write_busy_flag_q),
    .four_lane_enable_q(four_lane_enable_q), .secure_lock_q(secure_lock_q),
    .drive_sel_q(drive_sel_q));
`default_nettype wire

// *** bench/fsp_host.sv ***
// fsp_host.sv: host serial controller model for the flash pins
// assumes: clk is the block clock; sclk period 8 clk, mode 0
`timescale 1ns/10ps
`default_nettype none
module fsp_host (
    // block clock and returned data
    input  wire logic clk,
    input  wire logic so_q,
    // serial pins
    output var  logic sclk,
    output var  logic cs_b,
    output var  logic si
);
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        si   = 1'b0;
    end
    // whole bytes, msb first; rd keeps the last eight bits shifted out
    task automatic xfer(input logic [7:0] b [$], output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk) cs_b <= 1'b0;
        repeat (2) @(posedge clk);
        foreach (b[i]) for (int k = 7; k >= 0; k--) begin
            sclk <= 1'b0;
            si   <= b[i][k];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            rd = {rd[6:0], so_q};
        end
        sclk <= 1'b0;
        repeat (4) @(posedge clk);
        cs_b <= 1'b1;
        // released line shows the inverse so stale data never matches
        si   <= ~si;
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// testbench.sv: self-checking bench for the flash status and protect block
// assumes: core/ on the include path; busy counts shortened by parameters
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rst_b = 1'b0, wp_b = 1'b1, hold_b = 1'b1, hp_mode = 1'b0;
    logic sclk, cs_b, si, so_q, start, wr, pause, busy, qen, oe, seen_oe = 1'b0;
    logic [7:0] cmd_o, wdata, wbyte, rd;
    logic [22:0] addr_o, waddr;
    logic [2:0] lock;
    logic [1:0] drv;
    int n_mismatch = 0, num_checks = 0, n_start = 0, ns;
    // sel5, inv, start expected, code, address
    logic [38:0] tbl [0:13] = '{
        {5'h00, 2'b01, 8'h20, 24'h7FF000}, {5'h01, 2'b00, 8'h20, 24'h7E0000},
        {5'h01, 2'b01, 8'h52, 24'h7D8000}, {5'h00, 2'b10, 8'hD8, 24'h000000},
        {5'h07, 2'b11, 8'h02, 24'h000000}, {5'h01, 2'b11, 8'h20, 24'h7E0000},
        {5'h09, 2'b11, 8'h20, 24'h01F000}, {5'h09, 2'b10, 8'h02, 24'h020000},
        {5'h11, 2'b11, 8'h20, 24'h7FF000}, {5'h15, 2'b10, 8'h20, 24'h7F7000},
        {5'h19, 2'b10, 8'h20, 24'h001000}, {5'h07, 2'b11, 8'hC7, 24'h0},
        {5'h01, 2'b10, 8'h60, 24'h0}, {5'h18, 2'b01, 8'hC7, 24'h0}};
    always #20 clk = ~clk;
    always @(posedge clk) begin
        if (start === 1'b1) n_start++;
        if (oe === 1'b1) seen_oe <= 1'b1;
        if (wr === 1'b1) begin
            wbyte <= wdata;
            waddr <= addr_o;
        end
    end
    fsp_host h (.clk(clk), .so_q(so_q), .sclk(sclk), .cs_b(cs_b), .si(si));
    fsp_core #(.T_PROG_US(40), .T_ERASE_US(40), .T_SRW_US(1)) dut_u (
        .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .si(si), .wp_b(wp_b),
        .hold_b(hold_b), .so_q(so_q), .so_oe_q(oe), .high_perf_mode(hp_mode),
        .arr_start_q(start), .arr_cmd_q(cmd_o), .arr_addr_q(addr_o), .arr_wr_q(wr),
        .arr_wdata_q(wdata), .arr_pause_q(pause), .write_busy_flag_q(busy),
        .four_lane_enable_q(qen), .secure_lock_q(lock), .drive_sel_q(drv));
    task automatic close_out();
        if (n_mismatch == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) begin
            chk("busy_wait", 1, 0);
            close_out();
        end
    endtask
    task automatic reset();
        @(posedge clk) rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge clk);
    endtask
    task automatic cmd(input logic [7:0] c);
        h.xfer('{c}, rd);
    endtask
    task automatic rds(input logic [7:0] c, input logic [7:0] exp);
        h.xfer('{c, 8'h00}, rd);
        chk("status_read", rd, exp);
    endtask
    task automatic wrs(input logic [7:0] c, input logic [7:0] d);
        cmd(8'h06);
        h.xfer('{c, d}, rd);
        idle();
    endtask
    initial begin
        logic [7:0] q [$];
        reset();
        rds(8'h05, 8'h00);
        rds(8'h35, 8'h00);
        rds(8'h15, 8'h20);
        hold_b <= 1'b0;
        cmd(8'h06);
        hold_b <= 1'b1;
        rds(8'h05, 8'h00);
        ns = n_start;
        h.xfer('{8'h52, 8'h00, 8'h00, 8'h00}, rd);
        chk("locked_erase", n_start - ns, 0);
        h.xfer('{8'h01, 8'h1C}, rd);
        rds(8'h05, 8'h00);
        cmd(8'h06);
        rds(8'h05, 8'h02);
        cmd(8'h04);
        rds(8'h05, 8'h00);
        cmd(8'h06);
        h.xfer('{8'h01, 8'h1C}, rd);
        chk("srw_busy", busy, 1);
        idle();
        rds(8'h05, 8'h1C);
        foreach (tbl[i]) begin
            wrs(8'h01, {1'b0, tbl[i][38:34], 2'b00});
            wrs(8'h31, {1'b0, tbl[i][33], 6'h00});
            q = '{tbl[i][31:24]};
            if (tbl[i][31:24] != 8'hC7 && tbl[i][31:24] != 8'h60)
                q = {q, tbl[i][23:16], tbl[i][15:8], tbl[i][7:0]};
            if (tbl[i][31:24] == 8'h02)
                q.push_back(8'h5A);
            cmd(8'h06);
            ns = n_start;
            h.xfer(q, rd);
            chk("op_start", n_start - ns, tbl[i][32]);
            chk("op_busy", busy, tbl[i][32]);
            idle();
        end
        wrs(8'h01, 8'h00);
        wrs(8'h31, 8'h00);
        cmd(8'h06);
        h.xfer('{8'h20, 8'h00, 8'h00, 8'h00}, rd);
        chk("op_code", cmd_o, 8'h20);
        cmd(8'h75);
        rds(8'h35, 8'h80);
        chk("erase_pause", {pause, busy}, 2'b10);
        cmd(8'h7A);
        rds(8'h35, 8'h00);
        idle();
        cmd(8'h06);
        h.xfer('{8'h02, 8'h00, 8'h00, 8'h10, 8'hAA}, rd);
        chk("prog_byte", wbyte, 8'hAA);
        chk("prog_addr", waddr, 23'h000010);
        cmd(8'h75);
        rds(8'h35, 8'h04);
        cmd(8'h66);
        cmd(8'h99);
        rds(8'h35, 8'h00);
        wrs(8'h01, 8'h80);
        wp_b <= 1'b0;
        wrs(8'h01, 8'h84);
        rds(8'h05, 8'h80);
        wp_b <= 1'b1;
        wrs(8'h01, 8'h04);
        wrs(8'h31, 8'h01);
        wrs(8'h01, 8'h08);
        rds(8'h05, 8'h04);
        reset();
        rds(8'h35, 8'h00);
        wrs(8'h01, 8'h80);
        wrs(8'h31, 8'h01);
        wrs(8'h01, 8'h00);
        rds(8'h05, 8'h80);
        reset();
        wrs(8'h31, 8'h0A);
        chk("four_lane", qen, 1);
        chk("lock_bits", lock, 3'h1);
        wrs(8'h31, 8'h32);
        chk("lock_bits", lock, 3'h7);
        wrs(8'h01, 8'h80);
        wp_b <= 1'b0;
        wrs(8'h01, 8'h84);
        hold_b <= 1'b0;
        rds(8'h05, 8'h84);
        wp_b <= 1'b1;
        hold_b <= 1'b1;
        for (int d = 0; d < 4; d++) begin
            hp_mode <= d[0];
            wrs(8'h11, {1'b1, d[1:0], 5'h1F});
            chk("drive", drv, d[1:0]);
            rds(8'h15, {1'b0, d[1:0], d[0], 4'h0});
        end
        chk("so_enable", {seen_oe, oe}, 2'b10);
        close_out();
    end
endmodule
`default_nettype wire
